//--- dv/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // clock
   input wire logic aclk,
   // write channels
   output var logic [7:0] s_axi_awaddr,
   output var logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output var logic [31:0] s_axi_wdata,
   output var logic [3:0] s_axi_wstrb,
   output var logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output var logic s_axi_bready,
   // read channels
   output var logic [7:0] s_axi_araddr,
   output var logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output var logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
   end
   // released payload shows the inverse so a stale value cannot pass
   task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      logic aw, w;
      aw = 0;
      w = 0;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
      do begin
         @(posedge aclk);
         aw |= s_axi_awready;
         w |= s_axi_wready;
         if (aw) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
         if (w) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~v};
      end while (!(aw && w));
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do @(posedge aclk); while (!s_axi_arready);
      {s_axi_araddr, s_axi_arvalid} <= {~a, 1'b0};
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
endmodule // spi_host_model
`default_nettype wire

//--- dv/spi_sensor_page_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spi_sensor_page_checker (
   // watched slave ports
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
   sequence s_rwait; s_axi_rvalid && !s_axi_rready; endsequence
   property p_r_ans; s_ar |=> s_axi_rvalid; endproperty
   a_r_ans: assert property (p_r_ans) else $error("read answer missing");
   property p_r_cause; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
   a_r_cause: assert property (p_r_cause) else $error("read answer without request");
   property p_r_hold; s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer not held");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer not held");
   property p_b_cause; $rose(s_axi_bvalid) |-> $past(s_axi_awready || s_axi_wready); endproperty
   a_b_cause: assert property (p_b_cause) else $error("write answer without request");
   property p_no_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_no_ar: assert property (p_no_ar) else $error("read taken while answer pending");
   property p_err_zero; s_axi_rvalid && s_axi_rresp != 2'b00 |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
   property p_w_pulse; s_axi_wready |=> !s_axi_wready; endproperty
   a_w_pulse: assert property (p_w_pulse) else $error("write data ready not a pulse");
endmodule // spi_sensor_page_checker
bind spi_sensor_page spi_sensor_page_checker spi_sensor_page_checker_i (.*);
`default_nettype wire

//--- dv/spi_sensor_page_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi_defines.vh"
module spi_sensor_page_tb_top;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, w;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, rb[4];
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [4:0] id, ids[3] = '{5'h01, 5'h06, 5'h1f};
   logic [6:0] cf[4] = '{7'h46, 7'h5f, 7'h61, 7'h7f};
   logic [6:0] rs[4] = '{7'h5a, 7'h60, 7'h7a, 7'h40};
   int n_fail, checks_done, i, k;
   spi_sensor_page spi_sensor_page_i (.*);
   spi_host_model spi_host_model_i (.*);
   initial begin
      aclk = 0;
      forever #20 aclk = ~aclk;
   end
   task end_sim;
      $display("checks %0d errors %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      spi_host_model_i.wr(a, v, r);
   endtask
   task rd(input logic [7:0] a);
      spi_host_model_i.rd(a, d, r);
   endtask
   // select, command, then status and the four read-buffer words
   task acc(input logic [6:0] c, input logic [1:0] cmd, input logic [1:0] st);
      wr(8'h00, {25'h0, c});
      wr(8'h04, {30'h0, cmd});
      rd(8'h08);
      chk({30'h0, d[1:0]}, {30'h0, st});
      for (k = 0; k < 4; k++) begin
         rd(8'h20 + 8'(4 * k));
         rb[k] = d;
      end
   endtask
   task zero;
      for (k = 0; k < 4; k++) chk(rb[k], 32'h0);
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      end_sim;
   end
   initial begin
      {n_fail, checks_done, aresetn} = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      rd(8'h30);
      chk(d, 32'hffffffff);
      rd(8'h3c);
      chk({r, d[29:0]}, 32'h80000000);
      wr(8'h3c, 32'h1);
      chk({30'h0, r}, 32'h2);
      for (i = 0; i < 4; i++) begin
         wr(8'h10, 32'h12345670 + i);
         wr(8'h14, ~(32'h12345670 + i));
         acc(cf[i], 2'h2, 2'h1);
         chk(rb[0], 32'h12345670 + i);
         chk(rb[1], ~(32'h12345670 + i));
         acc(rs[i], 2'h2, 2'h3);
         zero;
         acc(rs[i], 2'h1, 2'h3);
         zero;
      end
      for (i = 0; i < 4; i++) begin
         acc(cf[i], 2'h1, 2'h1);
         chk(rb[0], 32'h12345670 + i);
         chk(rb[1], ~(32'h12345670 + i));
         chk(rb[2] | rb[3], 32'h0);
      end
      for (i = 0; i < 6; i++) begin
         id = ids[i / 2];
         w = i[0];
         acc({1'b0, w, id}, 2'h1, 2'h1);
         chk(rb[0], {`SPI_POWER, `SPI_DRIVER_REV, `SPI_DRIVER_IDENTIFIER, 3'h0, ~w, id[3:0]});
         chk(rb[1], {`SPI_RESOLUTION, `SPI_MAX_RANGE});
         chk(rb[2], {`SPI_FIFO_RSV, `SPI_MAX_RATE});
         chk(rb[3], {`SPI_MIN_RATE, `SPI_EVENT_SIZE, `SPI_FIFO_MAX});
      end
      wr(8'h30, 32'hffffffbf);
      acc(7'h06, 2'h1, 2'h1);
      zero;
      acc(7'h26, 2'h1, 2'h1);
      zero;
      end_sim;
   end
endmodule // spi_sensor_page_tb_top
`default_nettype wire

//--- rtl/spi_defines.vh
`ifndef SPI_DEFINES_VH
`define SPI_DEFINES_VH
// register byte offsets
`define SPI_ADDR_SELECT 8'h00
`define SPI_ADDR_CMD 8'h04
`define SPI_ADDR_STATUS 8'h08
`define SPI_ADDR_WBUF_LO 8'h10
`define SPI_ADDR_WBUF_HI 8'h14
`define SPI_ADDR_RBUF0 8'h20
`define SPI_ADDR_RBUF1 8'h24
`define SPI_ADDR_RBUF2 8'h28
`define SPI_ADDR_RBUF3 8'h2c
`define SPI_ADDR_SUPPORT 8'h30
// config number fields
`define SPI_CFG_ID_MSB 4
`define SPI_CFG_WAKE_BIT 5
`define SPI_CFG_CONF_BIT 6
`define SPI_CFG_LAST_ID 5'h1f
// reserved sensor ids
`define SPI_NO_ID 5'h00
`define SPI_RSV_ID_FIRST 5'h1a
`define SPI_RSV_ID_LAST 5'h1e
`define SPI_CONF_RSV_LAST 5'h05
// command bits
`define SPI_CMD_READ_BIT 0
`define SPI_CMD_WRITE_BIT 1
// information structure contents
`define SPI_DRIVER_IDENTIFIER 8'h5a
`define SPI_DRIVER_REV 8'h01
`define SPI_POWER 8'h0a
`define SPI_MAX_RANGE 16'h0010
`define SPI_RESOLUTION 16'h0010
`define SPI_MAX_RATE 16'h00c8
`define SPI_FIFO_RSV 16'h0000
`define SPI_FIFO_MAX 16'h0100
`define SPI_EVENT_SIZE 8'h0b
`define SPI_MIN_RATE 8'h01
`define SPI_SUPPORT_RST 32'hffffffff
`define SPI_AXI_OKAY 2'b00
`define SPI_AXI_SLVERR 2'b10
`endif

//--- rtl/spi_sensor_page.v
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "spi_defines.vh"

// Notes on behaviour
// - an information read for a sensor not marked supported returns all sixteen bytes as zero.
// - the maximum range reported is the fixed top-setting range, independent of any dynamic range written.
// - maximum range sits in bytes 4 and 5 as a 16-bit whole number already rounded up.
// - bytes 6 and 7 hold the resolution bit count of the underlying sensor.
// - byte 0 echoes bits 3:0 of the requested sensor type, with bit 4 set for non-wakeup sensors.
// - bytes 1, 2 and 3 hold the driver identifier, driver revision and supply current in 0.1 mA steps.
// - bytes 8 and 9 hold the highest output rate in hertz; the revision marks behaviour changes.
// - bytes 10 and 11 hold reserved FIFO space in packets, zero for a shared FIFO.
// - bytes 12 and 13 hold total FIFO size in packets.
// - byte 14 holds packet length including the type byte and byte 15 the lowest rate in hertz.
// - config numbers 70-95 and 97-127 hold per-sensor configuration, read back and written, except reserved slots.
// - config bits 0-4 pick the sensor, bit 5 wakeup and bit 6 configuration over information.
// - information is read only; configuration reads fill the read buffer and writes come from the write buffer.
module spi_sensor_page (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   reg [6:0] select_reg;
   reg [63:0] wbuf_reg;
   reg [127:0] rbuf_reg;
   reg [31:0] support_reg;
   reg done_reg;
   reg reserved_hit_reg;
   reg [63:0] conf_mem [0:63];
   reg aw_held_reg;
   reg w_held_reg;
   reg [7:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;

   wire [4:0] sel_id = select_reg[`SPI_CFG_ID_MSB:0];
   wire sel_wake = select_reg[`SPI_CFG_WAKE_BIT];
   wire sel_conf = select_reg[`SPI_CFG_CONF_BIT];
   wire [5:0] conf_index = {sel_wake, sel_id};
   wire sensor_ok = support_reg[sel_id];

   // reserved slots: id 0 and ids 26-30 in every quarter, plus 64-69 in the configuration area
   wire id_none = sel_id == `SPI_NO_ID;
   wire id_gap = sel_id >= `SPI_RSV_ID_FIRST && sel_id <= `SPI_RSV_ID_LAST;
   wire conf_low = sel_conf && !sel_wake && sel_id <= `SPI_CONF_RSV_LAST;
   reg sel_reserved;
   always @* begin
      sel_reserved = 1'b0;
      if (id_none || id_gap)
         sel_reserved = 1'b1;
      if (conf_low)
         sel_reserved = 1'b1;
   end

   // information structure, byte 0 lowest
   wire info_valid = sensor_ok && !sel_reserved;
   wire [15:0] max_range = `SPI_MAX_RANGE;
   wire [15:0] resolution = `SPI_RESOLUTION;
   wire [15:0] max_rate = `SPI_MAX_RATE;
   wire [15:0] fifo_rsv = `SPI_FIFO_RSV;
   wire [15:0] fifo_max = `SPI_FIFO_MAX;
   wire [7:0] info_byte [0:15];
   wire [127:0] info_image;
   // the type echo only has room for id bits 3:0 beside the non-wakeup flag
   assign info_byte[0] = {3'b000, ~sel_wake, sel_id[3:0]};
   assign info_byte[1] = `SPI_DRIVER_IDENTIFIER;
   assign info_byte[2] = `SPI_DRIVER_REV;
   assign info_byte[3] = `SPI_POWER;
   assign info_byte[4] = max_range[7:0];
   assign info_byte[5] = max_range[15:8];
   assign info_byte[6] = resolution[7:0];
   assign info_byte[7] = resolution[15:8];
   assign info_byte[8] = max_rate[7:0];
   assign info_byte[9] = max_rate[15:8];
   assign info_byte[10] = fifo_rsv[7:0];
   assign info_byte[11] = fifo_rsv[15:8];
   assign info_byte[12] = fifo_max[7:0];
   assign info_byte[13] = fifo_max[15:8];
   assign info_byte[14] = `SPI_EVENT_SIZE;
   assign info_byte[15] = `SPI_MIN_RATE;
   genvar b;
   generate
      for (b = 0; b < 16; b = b + 1) begin : g_info
         assign info_image[b*8 +: 8] = info_valid ? info_byte[b] : 8'h00;
      end
   endgenerate

   wire aw_have = aw_held_reg | s_axi_awvalid;
   wire w_have = w_held_reg | s_axi_wvalid;
   wire [7:0] aw_now = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
   wire [31:0] w_now = w_held_reg ? w_data_reg : s_axi_wdata;
   wire [3:0] s_now = w_held_reg ? w_strb_reg : s_axi_wstrb;
   wire wr_fire = aw_have && w_have && !s_axi_bvalid;
   // a channel counts once taken, earlier (held) or at this very edge
   wire aw_taken = aw_held_reg || (s_axi_awvalid && s_axi_awready);
   wire w_taken = w_held_reg || (s_axi_wvalid && s_axi_wready);
   wire wr_take = wr_fire && aw_taken && w_taken;

   // old value of the addressed register, so the strobes keep unwritten lanes
   reg [31:0] wr_old;
   always @* begin
      wr_old = 32'h0;
      case (aw_now)
         `SPI_ADDR_SELECT: wr_old = {25'h0, select_reg};
         `SPI_ADDR_WBUF_LO: wr_old = wbuf_reg[31:0];
         `SPI_ADDR_WBUF_HI: wr_old = wbuf_reg[63:32];
         `SPI_ADDR_SUPPORT: wr_old = support_reg;
         default: wr_old = 32'h0;
      endcase
   end

   wire [31:0] wr_merged;
   genvar m;
   generate
      for (m = 0; m < 4; m = m + 1) begin : g_merge
         assign wr_merged[m*8 +: 8] = s_now[m] ? w_now[m*8 +: 8] : wr_old[m*8 +: 8];
      end
   endgenerate

   // write address and data capture; each ready is a one-cycle pulse
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
      end else if (wr_take) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
      end
   end

   // writable offsets; anything else is answered with an error
   reg wr_addr_ok;
   always @* begin
      case (aw_now)
         `SPI_ADDR_SELECT,
         `SPI_ADDR_CMD,
         `SPI_ADDR_STATUS,
         `SPI_ADDR_WBUF_LO,
         `SPI_ADDR_WBUF_HI,
         `SPI_ADDR_SUPPORT: wr_addr_ok = 1'b1;
         default: wr_addr_ok = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SPI_AXI_OKAY;
      end else if (wr_take) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_addr_ok ? `SPI_AXI_OKAY : `SPI_AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         select_reg <= 7'h00;
         wbuf_reg <= 64'h0;
         support_reg <= `SPI_SUPPORT_RST;
      end else if (wr_take) begin
         case (aw_now)
            `SPI_ADDR_SELECT: select_reg <= wr_merged[6:0];
            `SPI_ADDR_WBUF_LO: wbuf_reg[31:0] <= wr_merged;
            `SPI_ADDR_WBUF_HI: wbuf_reg[63:32] <= wr_merged;
            `SPI_ADDR_SUPPORT: support_reg <= wr_merged;
            default: ;
         endcase
      end
   end

   wire wr_cmd = wr_take && aw_now == `SPI_ADDR_CMD;
   wire cmd_rd = wr_cmd && s_now[0] && w_now[`SPI_CMD_READ_BIT];
   wire cmd_wr = wr_cmd && s_now[0] && w_now[`SPI_CMD_WRITE_BIT];
   wire cmd_go = cmd_rd || cmd_wr;
   integer i;

   // command execution: a reserved slot touches no stored configuration
   always @(posedge aclk) begin
      if (!aresetn) begin
         done_reg <= 1'b0;
         reserved_hit_reg <= 1'b0;
         rbuf_reg <= 128'h0;
         for (i = 0; i < 64; i = i + 1)
            conf_mem[i] <= 64'h0;
      end else if (cmd_go) begin
         done_reg <= 1'b1;
         reserved_hit_reg <= sel_reserved;
         if (sel_reserved)
            rbuf_reg <= 128'h0;
         else if (!sel_conf)
            rbuf_reg <= info_image;
         else if (cmd_wr) begin
            conf_mem[conf_index] <= wbuf_reg;
            rbuf_reg <= {64'h0, wbuf_reg};
         end else
            rbuf_reg <= {64'h0, conf_mem[conf_index]};
      end
   end

   wire [31:0] rbuf_word [0:3];
   genvar q;
   generate
      for (q = 0; q < 4; q = q + 1) begin : g_rbuf
         assign rbuf_word[q] = rbuf_reg[q*32 +: 32];
      end
   endgenerate

   // read data and response for the offered read address
   reg [31:0] rd_word;
   reg [1:0] rd_resp;
   always @* begin
      rd_word = 32'h0;
      rd_resp = `SPI_AXI_OKAY;
      case (s_axi_araddr)
         `SPI_ADDR_SELECT: rd_word = {25'h0, select_reg};
         `SPI_ADDR_CMD: rd_word = 32'h0;
         `SPI_ADDR_STATUS: rd_word = {30'h0, reserved_hit_reg, done_reg};
         `SPI_ADDR_WBUF_LO: rd_word = wbuf_reg[31:0];
         `SPI_ADDR_WBUF_HI: rd_word = wbuf_reg[63:32];
         `SPI_ADDR_RBUF0: rd_word = rbuf_word[0];
         `SPI_ADDR_RBUF1: rd_word = rbuf_word[1];
         `SPI_ADDR_RBUF2: rd_word = rbuf_word[2];
         `SPI_ADDR_RBUF3: rd_word = rbuf_word[3];
         `SPI_ADDR_SUPPORT: rd_word = support_reg;
         default: rd_resp = `SPI_AXI_SLVERR;
      endcase
   end

   // read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `SPI_AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_resp;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule // spi_sensor_page
`default_nettype wire
